// *** inc/mdcr_pkg.sv ***
// Constants for the display configuration register bank
package mdcr_pkg;
  localparam logic [15:0] ADR_POS6 = 16'h001d;
  localparam logic [15:0] ADR_SLAVE = 16'h0020;
  localparam logic [15:0] ADR_IDENT = 16'h0021;
  localparam logic [15:0] ADR_BAUD = 16'h0022;
  localparam logic [15:0] ADR_PERMIT = 16'h0023;
  localparam logic [15:0] ADR_DELAY = 16'h0025;
  localparam logic [15:0] ADR_SUPP = 16'h0026;
  localparam logic [15:0] ADR_GAP = 16'h0027;
  localparam logic [15:0] ADR_LUM_ST = 16'h002d;
  localparam logic [15:0] ADR_EDIT = 16'h002f;
  localparam logic [15:0] ADR_FORMAT = 16'h0030;
  localparam logic [15:0] ADR_LUM_LV = 16'h0031;
  localparam logic [15:0] ADR_VAL_LO = 16'h0001;
  localparam logic [15:0] ADR_VAL_HI = 16'h0003;
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WR_ONE = 8'h06;
  localparam logic [7:0] FN_WR_MANY = 8'h10;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_PERM = 8'h08;
  localparam logic [15:0] SLAVE_MIN = 16'h0001;
  localparam logic [15:0] SLAVE_MAX = 16'h00ff;
  localparam logic [15:0] BAUD_MAX = 16'h0007;
  localparam logic [15:0] FLAG_MAX = 16'h0001;
  localparam logic [15:0] DELAY_MAX = 16'h0005;
  localparam logic [15:0] GAP_MAX = 16'h0063;
  localparam logic [15:0] LUM_MIN = 16'h0001;
  localparam logic [15:0] LUM_MAX = 16'h0008;
  localparam logic [15:0] FORMAT_MAX = 16'h0003;
  localparam int BLINK_BIT = 12;
  localparam logic [7:0] SLAVE_RST = 8'h01;
  localparam logic [2:0] BAUD_RST = 3'h3;
  localparam logic PERMIT_RST = 1'b1;
  localparam logic [2:0] DELAY_RST = 3'h0;
  localparam logic SUPP_RST = 1'b1;
  localparam logic [6:0] GAP_RST = 7'h00;
  localparam logic [3:0] LUM_RST = 4'h8;
  localparam logic EDIT_RST = 1'b0;
  localparam logic [1:0] FORMAT_RST = 2'h0;
  localparam logic BLINK_RST = 1'b0;
  localparam int CLK_HZ = 100_000_000;
  localparam int SEC_NS = 1_000_000_000;
  localparam int CLK_NS = 10;
  localparam int CYC_PER_SEC = SEC_NS / CLK_NS;
  // Extra reply delay options, in character times
  localparam logic [7:0] DLY_1 = 8'h0a;
  localparam logic [7:0] DLY_2 = 8'h14;
  localparam logic [7:0] DLY_3 = 8'h32;
  localparam logic [7:0] DLY_4 = 8'h64;
  localparam logic [7:0] DLY_5 = 8'hc8;
endpackage : mdcr_pkg

// *** hdl/mdcr_regs.sv ***
// Configuration register bank of a serial-bus numeric display slave
// Behaviour
// - Slave address register holds values 1 to 255.
// - Reply to an address write goes out under the old address.
// - Fixed identification code, read only, writes refused.
// - Line speed code 0..7 selects 1200 up to 115200 baud.
// - Reply to a line speed write uses the new speed.
// - Write permit flag: zero blocks bus writes, one allows them.
// - Bus may clear the permit; only the local menu sets it.
// - Writes while blocked answer exception eight.
// - Reply delay code 0..5 adds none, 10, 20, 50, 100, 200.
// - Suppress flag zero blocks replies to value and point writes.
// - Frame gap check: zero off, 1..99 seconds maximum gap.
// - Stored brightness 1..8 also sets brightness at once when written.
// - Live brightness 1..8 changes brightness at once.
// - Live brightness is volatile; reset sets it to 8, not to the stored value.
// - Edit style: zero per digit, one ramp editing.
// - Value format 0..3; 32-bit forms need both value words.
// - Only functions 3, 6, 16; others answer exception one.
// - Unknown register gives exception two, bad value exception three.
// - Sixth position attribute register exists on six-position builds only.
// - Bit twelve of sixth position attributes enables blinking.
`timescale 1ns/1ps
module mdcr_regs
  import mdcr_pkg::*;
#(
  parameter bit SIX_POS = 1'b1,
  parameter logic [15:0] IDENT_CODE = 16'h5a5a,
  parameter int SEC_CYCLES = CYC_PER_SEC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_data,
  input wire logic req_ext_ok,
  input wire logic [15:0] ext_rdata,
  output logic ext_wr,
  input wire logic frame_rx,
  input wire logic menu_wr,
  input wire logic [15:0] menu_addr,
  input wire logic [15:0] menu_data,
  output logic rsp_valid,
  output logic [7:0] rsp_exc,
  output logic [15:0] rsp_data,
  output logic rsp_send,
  output logic [7:0] rsp_slave,
  output logic [2:0] rsp_baud,
  output logic [7:0] rsp_delay_chars,
  output logic [7:0] slave_addr,
  output logic [2:0] baud_code,
  output logic write_permit,
  output logic [2:0] delay_code,
  output logic reply_on_value,
  output logic [6:0] gap_limit,
  output logic gap_expired,
  output logic [3:0] stored_lum,
  output logic [3:0] display_lum,
  output logic ramp_edit,
  output logic [1:0] value_format,
  output logic blink_flag
);

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] d);
    logic ok;
    ok = 1'b1;
    if (a == ADR_SLAVE) begin
      ok = (d >= SLAVE_MIN) && (d <= SLAVE_MAX);
    end else if (a == ADR_BAUD) begin
      ok = d <= BAUD_MAX;
    end else if (a == ADR_PERMIT || a == ADR_SUPP || a == ADR_EDIT) begin
      ok = d <= FLAG_MAX;
    end else if (a == ADR_DELAY) begin
      ok = d <= DELAY_MAX;
    end else if (a == ADR_GAP) begin
      ok = d <= GAP_MAX;
    end else if (a == ADR_LUM_ST || a == ADR_LUM_LV) begin
      ok = (d >= LUM_MIN) && (d <= LUM_MAX);
    end else if (a == ADR_FORMAT) begin
      ok = d <= FORMAT_MAX;
    end
    return ok;
  endfunction : in_range

  function automatic logic [7:0] delay_chars(input logic [2:0] code);
    logic [7:0] n;
    n = 8'h00;
    case (code)
      3'd1: n = DLY_1;
      3'd2: n = DLY_2;
      3'd3: n = DLY_3;
      3'd4: n = DLY_4;
      3'd5: n = DLY_5;
      default: n = 8'h00;
    endcase
    return n;
  endfunction : delay_chars

  logic [7:0] slave_ff;
  logic [2:0] baud_ff;
  logic permit_ff;
  logic [2:0] delay_ff;
  logic supp_ff;
  logic [6:0] gap_ff;
  logic [3:0] lum_st_ff;
  logic [3:0] lum_now_ff;
  logic edit_ff;
  logic [1:0] format_ff;
  logic blink_ff;
  logic rsp_valid_ff;
  logic [7:0] rsp_exc_ff;
  logic [15:0] rsp_data_ff;
  logic rsp_send_ff;
  logic [7:0] rsp_slave_ff;
  logic [2:0] rsp_baud_ff;
  logic [7:0] rsp_delay_ff;
  logic [31:0] tick_ff;
  logic [6:0] sec_ff;
  logic gap_exp_ff;

  // Request decode
  wire is_read = req_func == FN_READ;
  wire is_write = (req_func == FN_WR_ONE) || (req_func == FN_WR_MANY);
  wire hit_pos6 = SIX_POS && (req_addr == ADR_POS6);
  wire hit_ident = req_addr == ADR_IDENT;
  wire hit_local = hit_pos6 || (req_addr == ADR_SLAVE) || hit_ident || (req_addr == ADR_BAUD)
    || (req_addr == ADR_PERMIT) || (req_addr == ADR_DELAY) || (req_addr == ADR_SUPP)
    || (req_addr == ADR_GAP) || (req_addr == ADR_LUM_ST) || (req_addr == ADR_EDIT)
    || (req_addr == ADR_FORMAT) || (req_addr == ADR_LUM_LV);
  wire known = hit_local || req_ext_ok;
  wire bus_range_ok = req_ext_ok || in_range(req_addr, req_data);

  // Function first, then address, then permission, then value
  wire [7:0] exc =
    !(is_read || is_write) ? EXC_FUNC :
    !known ? EXC_ADDR :
    (is_write && hit_ident) ? EXC_ADDR :
    (is_write && !permit_ff) ? EXC_PERM :
    (is_write && !bus_range_ok) ? EXC_VALUE :
    EXC_NONE;

  wire bus_ok = req_valid && is_write && (exc == EXC_NONE);
  wire bus_wr = bus_ok && !req_ext_ok;
  assign ext_wr = bus_ok && req_ext_ok;

  // Menu edits bypass the permit flag but still obey ranges
  wire menu_ok = menu_wr && in_range(menu_addr, menu_data);
  wire wr_en = menu_ok || bus_wr;
  wire [15:0] wr_addr = menu_ok ? menu_addr : req_addr;
  wire [15:0] wr_data = menu_ok ? menu_data : req_data;
  wire wr_is_menu = menu_ok;

  wire we_slave = wr_en && (wr_addr == ADR_SLAVE);
  wire we_baud = wr_en && (wr_addr == ADR_BAUD);
  wire we_permit = wr_en && (wr_addr == ADR_PERMIT);
  wire we_delay = wr_en && (wr_addr == ADR_DELAY);
  wire we_supp = wr_en && (wr_addr == ADR_SUPP);
  wire we_gap = wr_en && (wr_addr == ADR_GAP);
  wire we_lum_st = wr_en && (wr_addr == ADR_LUM_ST);
  wire we_lum_lv = wr_en && (wr_addr == ADR_LUM_LV);
  wire we_edit = wr_en && (wr_addr == ADR_EDIT);
  wire we_format = wr_en && (wr_addr == ADR_FORMAT);
  wire we_pos6 = wr_en && SIX_POS && (wr_addr == ADR_POS6);

  // A bus write of one leaves the flag alone; only the menu raises it
  wire nxt_permit = !we_permit ? permit_ff :
    wr_is_menu ? wr_data[0] :
    (permit_ff && wr_data[0]);

  // Stored value also takes effect at once when edited
  wire [3:0] nxt_lum_now = we_lum_lv ? wr_data[3:0] :
    we_lum_st ? wr_data[3:0] : lum_now_ff;

  // Read mux
  wire [15:0] rd_local =
    hit_pos6 ? {3'b000, blink_ff, 12'h000} :
    (req_addr == ADR_SLAVE) ? {8'h00, slave_ff} :
    hit_ident ? IDENT_CODE :
    (req_addr == ADR_BAUD) ? {13'h0000, baud_ff} :
    (req_addr == ADR_PERMIT) ? {15'h0000, permit_ff} :
    (req_addr == ADR_DELAY) ? {13'h0000, delay_ff} :
    (req_addr == ADR_SUPP) ? {15'h0000, supp_ff} :
    (req_addr == ADR_GAP) ? {9'h000, gap_ff} :
    (req_addr == ADR_LUM_ST) ? {12'h000, lum_st_ff} :
    (req_addr == ADR_EDIT) ? {15'h0000, edit_ff} :
    (req_addr == ADR_FORMAT) ? {14'h0000, format_ff} :
    (req_addr == ADR_LUM_LV) ? {12'h000, lum_now_ff} :
    16'h0000;
  wire [15:0] nxt_rsp_data = (exc != EXC_NONE || !is_read) ? req_data :
    req_ext_ok ? ext_rdata : rd_local;

  // Value and point writes may be silent
  wire val_reg = req_ext_ok && (req_addr >= ADR_VAL_LO) && (req_addr <= ADR_VAL_HI);
  wire nxt_send = !(is_write && (exc == EXC_NONE) && val_reg && !supp_ff);

  // Reply goes under the address held before this request
  wire [7:0] nxt_rsp_slave = slave_ff;
  // Reply uses the speed this request selects
  wire [2:0] nxt_rsp_baud = (bus_wr && we_baud) ? req_data[2:0] : baud_ff;

  // One short process per configuration register keeps each reset value beside its update
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      slave_ff <= SLAVE_RST;
    end else begin
      slave_ff <= we_slave ? wr_data[7:0] : slave_ff;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      baud_ff <= BAUD_RST;
    end else begin
      baud_ff <= we_baud ? wr_data[2:0] : baud_ff;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      permit_ff <= PERMIT_RST;
    end else begin
      permit_ff <= nxt_permit;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      delay_ff <= DELAY_RST;
    end else begin
      delay_ff <= we_delay ? wr_data[2:0] : delay_ff;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      supp_ff <= SUPP_RST;
    end else begin
      supp_ff <= we_supp ? wr_data[0] : supp_ff;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gap_ff <= GAP_RST;
    end else begin
      gap_ff <= we_gap ? wr_data[6:0] : gap_ff;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      edit_ff <= EDIT_RST;
    end else begin
      edit_ff <= we_edit ? wr_data[0] : edit_ff;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      format_ff <= FORMAT_RST;
    end else begin
      format_ff <= we_format ? wr_data[1:0] : format_ff;
    end
  end

  // Only bit twelve is kept; the other attribute bits read back as zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      blink_ff <= BLINK_RST;
    end else begin
      blink_ff <= we_pos6 ? wr_data[BLINK_BIT] : blink_ff;
    end
  end

  // Both levels reset to LUM_RST; live brightness does not restart from the stored level
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lum_st_ff <= LUM_RST;
    end else begin
      lum_st_ff <= we_lum_st ? wr_data[3:0] : lum_st_ff;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lum_now_ff <= LUM_RST;
    end else begin
      lum_now_ff <= nxt_lum_now;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= req_valid;
    end
  end

  // Reply fields hold until the next request, so the framer may read them late
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_exc_ff <= EXC_NONE;
      rsp_data_ff <= 16'h0000;
      rsp_send_ff <= 1'b0;
      rsp_slave_ff <= SLAVE_RST;
      rsp_baud_ff <= BAUD_RST;
      rsp_delay_ff <= 8'h00;
    end else begin
      if (req_valid) begin
        rsp_exc_ff <= exc;
        rsp_data_ff <= nxt_rsp_data;
        rsp_send_ff <= nxt_send;
        rsp_slave_ff <= nxt_rsp_slave;
        rsp_baud_ff <= nxt_rsp_baud;
        rsp_delay_ff <= delay_chars(delay_ff);
      end
    end
  end

  // Gap timer restarts on every received frame
  wire tick_end = tick_ff == 32'(SEC_CYCLES - 1);
  wire [31:0] nxt_tick = (frame_rx || tick_end) ? 32'h0000_0000 : tick_ff + 32'h0000_0001;
  wire sec_full = sec_ff == 7'h7f;
  wire [6:0] nxt_sec = frame_rx ? 7'h00 :
    (tick_end && !sec_full) ? sec_ff + 7'h01 : sec_ff;
  wire nxt_gap_exp = !frame_rx && (gap_ff != 7'h00) && (nxt_sec >= gap_ff);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tick_ff <= 32'h0000_0000;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  // Saturating, so a long silence cannot wrap round and clear the alarm
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sec_ff <= 7'h00;
    end else begin
      sec_ff <= nxt_sec;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gap_exp_ff <= 1'b0;
    end else begin
      gap_exp_ff <= nxt_gap_exp;
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp_exc = rsp_exc_ff;
  assign rsp_data = rsp_data_ff;
  assign rsp_send = rsp_send_ff;
  assign rsp_slave = rsp_slave_ff;
  assign rsp_baud = rsp_baud_ff;
  assign rsp_delay_chars = rsp_delay_ff;
  assign slave_addr = slave_ff;
  assign baud_code = baud_ff;
  assign write_permit = permit_ff;
  assign delay_code = delay_ff;
  assign reply_on_value = supp_ff;
  assign gap_limit = gap_ff;
  assign gap_expired = gap_exp_ff;
  assign stored_lum = lum_st_ff;
  assign display_lum = lum_now_ff;
  assign ramp_edit = edit_ff;
  assign value_format = format_ff;
  assign blink_flag = blink_ff;

endmodule : mdcr_regs

// *** verification/mdcr_master_model.sv ***
// Bus master model issuing decoded register requests
`timescale 1ns/1ps
module mdcr_master_model (
  input wire logic mclk,
  output logic req_valid,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_data,
  output logic req_ext_ok
);
  initial begin
    req_valid = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_data = 16'h0000;
    req_ext_ok = 1'b0;
  end
  // After one cycle valid drops and function, address and data are driven inverted; req_ext_ok keeps its value
  task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    #1;
    req_valid = 1'b1;
    req_func = f;
    req_addr = a;
    req_data = d;
    req_ext_ok = a >= 16'h0001 && a <= 16'h001c;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    req_func = ~f;
    req_addr = ~a;
    req_data = ~d;
  endtask : send
endmodule : mdcr_master_model

// *** verification/mdcr_regs_monitor.sv ***
// Port checker for the configuration register bank
`timescale 1ns/1ps
module mdcr_regs_monitor
  import mdcr_pkg::*;
#(
  parameter logic [15:0] IDENT_CODE = 16'h5a5a
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_data,
  input wire logic req_ext_ok,
  input wire logic ext_wr,
  input wire logic menu_wr,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_exc,
  input wire logic [15:0] rsp_data,
  input wire logic [7:0] rsp_slave,
  input wire logic [2:0] rsp_baud,
  input wire logic [7:0] slave_addr,
  input wire logic [2:0] baud_code,
  input wire logic write_permit,
  input wire logic [3:0] display_lum,
  input wire logic blink_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire legal_fn = req_func == FN_READ || req_func == FN_WR_ONE || req_func == FN_WR_MANY;
  sequence wr_ok(logic [15:0] a);
    req_valid && req_func == FN_WR_ONE && req_addr == a && write_permit && !menu_wr;
  endsequence
  answer_pulse_a: assert property (req_valid |=> rsp_valid) else $error("request not answered");
  bad_func_a: assert property (req_valid && !legal_fn |=> rsp_exc == EXC_FUNC)
    else $error("illegal function not refused");
  ident_read_a: assert property (req_valid && req_func == FN_READ && req_addr == ADR_IDENT
    |=> rsp_exc == EXC_NONE && rsp_data == IDENT_CODE) else $error("identification read wrong");
  ident_write_a: assert property (req_valid && req_func == FN_WR_ONE && req_addr == ADR_IDENT
    |=> rsp_exc == EXC_ADDR) else $error("identification write not refused");
  no_permit_a: assert property (req_valid && req_func == FN_WR_ONE && req_addr == ADR_SLAVE && !write_permit
    && !menu_wr |=> rsp_exc == EXC_PERM && $stable(slave_addr)) else $error("blocked write not refused");
  old_addr_a: assert property (wr_ok(ADR_SLAVE) |=> rsp_slave == $past(slave_addr))
    else $error("reply address not the old one");
  addr_range_a: assert property (wr_ok(ADR_SLAVE) ##0 req_data == 16'h0000
    |=> rsp_exc == EXC_VALUE && $stable(slave_addr)) else $error("address zero accepted");
  new_baud_a: assert property (wr_ok(ADR_BAUD) ##0 req_data <= BAUD_MAX
    |=> rsp_baud == $past(req_data[2:0]) && baud_code == rsp_baud) else $error("reply speed not new");
  permit_set_a: assert property ($rose(write_permit) |-> $past(menu_wr))
    else $error("permit set without menu");
  live_lum_a: assert property (wr_ok(ADR_LUM_LV) ##0 req_data inside {[1:8]}
    |=> display_lum == $past(req_data[3:0])) else $error("live brightness not applied");
  blink_set_a: assert property (wr_ok(ADR_POS6) |=> blink_flag == $past(req_data[BLINK_BIT]))
    else $error("blink flag wrong");
  ext_write_a: assert property (ext_wr == (req_valid && req_ext_ok && write_permit
    && (req_func == FN_WR_ONE || req_func == FN_WR_MANY))) else $error("outside write strobe wrong");
endmodule : mdcr_regs_monitor
bind mdcr_regs mdcr_regs_monitor #(.IDENT_CODE(IDENT_CODE)) u_mon (.mclk, .reset_n, .req_valid, .req_func,
  .req_addr, .req_data, .req_ext_ok, .ext_wr, .menu_wr, .rsp_valid, .rsp_exc, .rsp_data, .rsp_slave,
  .rsp_baud, .slave_addr, .baud_code, .write_permit, .display_lum, .blink_flag);

// *** verification/mdcr_regs_test.sv ***
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module mdcr_regs_test import mdcr_pkg::*;;
  localparam logic [15:0] ID = 16'h3c3c; // Arbitrary code
  localparam int SECS = 10;
  logic mclk = 1'b0, reset_n = 1'b0, frame_rx = 1'b0, menu_wr = 1'b0;
  logic [15:0] menu_addr = 16'h0000, menu_data = 16'h0000, ext_rdata = 16'h1234;
  logic req_valid, req_ext_ok, ext_wr, rsp_valid, rsp_send, write_permit, reply_on_value, gap_expired;
  logic ramp_edit, blink_flag;
  logic [7:0] req_func, rsp_exc, rsp_slave, rsp_delay_chars, slave_addr;
  logic [15:0] req_addr, req_data, rsp_data;
  logic [2:0] rsp_baud, baud_code, delay_code;
  logic [6:0] gap_limit;
  logic [3:0] stored_lum, display_lum;
  logic [1:0] value_format;
  logic [7:0] dly [6] = '{8'h00, 8'h0a, 8'h14, 8'h32, 8'h64, 8'hc8};
  logic [7:0] bad [4] = '{8'h01, 8'h04, 8'h05, 8'h0f};
  int error_cnt = 0, checks_done = 0;
  always #5 mclk = ~mclk;
  mdcr_master_model m (.mclk, .req_valid, .req_func, .req_addr, .req_data, .req_ext_ok);
  mdcr_regs #(.IDENT_CODE(ID), .SEC_CYCLES(SECS)) dut (.mclk, .reset_n, .req_valid, .req_func, .req_addr,
    .req_data, .req_ext_ok, .ext_rdata, .ext_wr, .frame_rx, .menu_wr, .menu_addr, .menu_data, .rsp_valid,
    .rsp_exc, .rsp_data, .rsp_send, .rsp_slave, .rsp_baud, .rsp_delay_chars, .slave_addr, .baud_code,
    .write_permit, .delay_code, .reply_on_value, .gap_limit, .gap_expired, .stored_lum, .display_lum,
    .ramp_edit, .value_format, .blink_flag);
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic acc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d, input logic [7:0] ex);
    m.send(f, a, d);
    chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
    chk("rsp_exc", {8'h00, ex}, {8'h00, rsp_exc});
  endtask : acc
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    acc(FN_READ, a, 16'h0000, EXC_NONE);
    chk("rsp_data", exp, rsp_data);
  endtask : rd
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #200_000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge mclk);
    #1 reset_n = 1'b1;
    rd(ADR_SLAVE, 16'h0001);
    rd(ADR_IDENT, ID);
    acc(FN_WR_ONE, ADR_IDENT, 16'h0000, EXC_ADDR);
    acc(FN_WR_ONE, ADR_SLAVE, 16'h0002, EXC_NONE);
    chk("rsp_slave", 16'h0001, {8'h00, rsp_slave});
    acc(FN_WR_ONE, ADR_SLAVE, 16'h0100, EXC_VALUE);
    chk("slave_addr", 16'h0002, {8'h00, slave_addr});
    for (int i = 0; i < 9; i++) begin
      acc(FN_WR_ONE, ADR_BAUD, 16'(i), i < 8 ? EXC_NONE : EXC_VALUE);
      chk("rsp_baud", 16'(i > 7 ? 7 : i), {13'h0000, rsp_baud});
      chk("baud_code", 16'(i > 7 ? 7 : i), {13'h0000, baud_code});
    end
    for (int i = 0; i < 7; i++) begin
      acc(FN_WR_ONE, ADR_DELAY, 16'(i), i < 6 ? EXC_NONE : EXC_VALUE);
      rd(ADR_DELAY, 16'(i > 5 ? 5 : i));
      chk("rsp_delay_chars", {8'h00, dly[i > 5 ? 5 : i]}, {8'h00, rsp_delay_chars});
    end
    acc(FN_WR_ONE, ADR_GAP, 16'h0064, EXC_VALUE);
    acc(FN_WR_ONE, ADR_GAP, 16'h0001, EXC_NONE);
    chk("gap_limit", 16'h0001, {9'h000, gap_limit});
    frame_rx = 1'b1;
    @(posedge mclk) #1 frame_rx = 1'b0;
    // One second is SECS cycles after the frame edge; look either side of it
    repeat (SECS - 1) @(posedge mclk);
    #1 chk("gap_expired", 16'h0000, {15'h0000, gap_expired});
    @(posedge mclk) #1 chk("gap_expired", 16'h0001, {15'h0000, gap_expired});
    frame_rx = 1'b1;
    @(posedge mclk) #1 frame_rx = 1'b0;
    chk("gap_expired", 16'h0000, {15'h0000, gap_expired});
    acc(FN_WR_ONE, ADR_GAP, 16'h0000, EXC_NONE);
    repeat (SECS + 2) @(posedge mclk);
    #1 chk("gap_expired", 16'h0000, {15'h0000, gap_expired});
    foreach (bad[i]) begin
      acc(bad[i], ADR_EDIT, 16'h0000, EXC_FUNC);
    end
    acc(FN_WR_MANY, ADR_EDIT, 16'h0001, EXC_NONE);
    chk("ramp_edit", 16'h0001, {15'h0000, ramp_edit});
    acc(FN_READ, 16'h0024, 16'h0000, EXC_ADDR);
    rd(16'h0005, 16'h1234);
    acc(FN_WR_ONE, ADR_FORMAT, 16'h0004, EXC_VALUE);
    acc(FN_WR_ONE, ADR_FORMAT, 16'h0002, EXC_NONE);
    chk("value_format", 16'h0002, {14'h0000, value_format});
    acc(FN_WR_ONE, ADR_VAL_LO, 16'h0001, EXC_NONE);
    acc(FN_WR_ONE, 16'h0002, 16'h0002, EXC_NONE);
    acc(FN_WR_ONE, ADR_POS6, 16'h1000, EXC_NONE);
    chk("blink_flag", 16'h0001, {15'h0000, blink_flag});
    acc(FN_WR_ONE, ADR_POS6, 16'hefff, EXC_NONE);
    chk("blink_flag", 16'h0000, {15'h0000, blink_flag});
    rd(ADR_POS6, 16'h0000);
    acc(FN_WR_ONE, ADR_SUPP, 16'h0000, EXC_NONE);
    chk("reply_on_value", 16'h0000, {15'h0000, reply_on_value});
    acc(FN_WR_ONE, ADR_VAL_LO, 16'h0005, EXC_NONE);
    chk("rsp_send", 16'h0000, {15'h0000, rsp_send});
    acc(FN_WR_ONE, ADR_SUPP, 16'h0001, EXC_NONE);
    acc(FN_WR_ONE, ADR_VAL_HI, 16'h0001, EXC_NONE);
    chk("rsp_send", 16'h0001, {15'h0000, rsp_send});
    // Frequent dimming goes to the live register, stored one only once
    acc(FN_WR_ONE, ADR_LUM_ST, 16'h0005, EXC_NONE);
    chk("stored_lum", 16'h0005, {12'h000, stored_lum});
    acc(FN_WR_ONE, ADR_LUM_LV, 16'h0003, EXC_NONE);
    acc(FN_WR_ONE, ADR_LUM_LV, 16'h0009, EXC_VALUE);
    chk("display_lum", 16'h0003, {12'h000, display_lum});
    acc(FN_WR_ONE, ADR_PERMIT, 16'h0001, EXC_NONE);
    acc(FN_WR_ONE, ADR_PERMIT, 16'h0000, EXC_NONE);
    chk("write_permit", 16'h0000, {15'h0000, write_permit});
    acc(FN_WR_ONE, ADR_SLAVE, 16'h0007, EXC_PERM);
    rd(ADR_SLAVE, 16'h0002);
    menu_addr = ADR_PERMIT;
    menu_data = 16'h0001;
    menu_wr = 1'b1;
    @(posedge mclk) #1 menu_wr = 1'b0;
    chk("write_permit", 16'h0001, {15'h0000, write_permit});
    reset_n = 1'b0;
    @(posedge mclk) #1 reset_n = 1'b1;
    chk("display_lum", {12'h000, LUM_RST}, {12'h000, display_lum});
    rd(ADR_LUM_LV, 16'h0008);
    print_verdict();
  end
endmodule : mdcr_regs_test
